// >>> lics_cfg.svh
// constants of the li-ion charge cycle sequencer: offsets, field positions, reset values, timing
// assumes a single 125 mhz clock and a plain register port with word indices
//
// Notes on behaviour
// RULE_01 - start a charge when a source is present and enable is set; pull detect low
// RULE_02 - with both sources present the adapter path is taken
// RULE_03 - end-of-charge pin is pulled low as the charge begins
// RULE_04 - below trickle threshold charge with the small trickle current until threshold reached
// RULE_05 - above trickle threshold enter fast charge with resistor or usb current
// RULE_06 - near selected charge voltage (four settings) switch to constant voltage
// RULE_07 - current at ten percent level releases end-of-charge pin and enters maintenance
// RULE_08 - maintenance keeps watching battery and tops it up when it sags
// RULE_09 - maintenance lasts until enable cleared or source removed, either stops charge
// RULE_10 - trickle source only in trickle; above threshold it is off, constant current used
// RULE_11 - trickle threshold and current come from factory bits, not registers
// RULE_12 - usb input charges only at the internal usb current setting
// RULE_13 - adapter path uses usb current or resistor current per select bit
// RULE_14 - factory bits select external power device or external sense resistor
// RULE_15 - usb current field: 00 low, 01 mid, 10 high, 11 usb charge off
// RULE_16 - watchdog runs in fast charge; expiry without refresh stops the charge
// RULE_17 - inputs registered; sequencer idle and charge off in reset or when disabled
`ifndef LICS_CFG_SVH
`define LICS_CFG_SVH

// ---------------------------------------------------------------
// register word indices
// ---------------------------------------------------------------
`define LICS_OFS_CTRL_A 3'h0
`define LICS_OFS_CTRL_B 3'h1
`define LICS_OFS_STATUS 3'h2
`define LICS_OFS_IRQ_ST 3'h3
`define LICS_OFS_IRQ_MASK 3'h4

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LICS_A_USBI_LSB 6
`define LICS_A_SEL_BIT 5
`define LICS_A_VSEL_LSB 3
`define LICS_B_EN_BIT 0
`define LICS_B_WREF_BIT 1
`define LICS_B_WDEN_BIT 2
`define LICS_B_WPER_LSB 3
`define LICS_IRQ_START 0
`define LICS_IRQ_EOC 1
`define LICS_IRQ_WDOG 2
`define LICS_IRQ_LOST 3

// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define LICS_CTRL_A_RST 8'h00
`define LICS_EN_RST 1'b0
`define LICS_WDEN_RST 1'b1
`define LICS_WPER_RST 2'h0
`define LICS_IRQ_MASK_RST 4'h0
`define LICS_USBI_OFF 2'h3

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define LICS_CLK_HZ 125000000
`define LICS_WD_TICK_S 1
`define LICS_WD_TICK_CYCLES (`LICS_WD_TICK_S * `LICS_CLK_HZ)
`define LICS_SEC_PER_MIN 60
`define LICS_WD_MIN_0 1
`define LICS_WD_MIN_1 15
`define LICS_WD_MIN_2 30
`define LICS_WD_MIN_3 60

`endif

// >>> lics_pkg.sv
// types of the li-ion charge cycle sequencer
// assumes lics_cfg.svh is on the include path
package lics_pkg;

  // ---------------------------------------------------------------
  // sequencer phases
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    LICS_IDLE = 6'h01,
    LICS_TRICKLE = 6'h02,
    LICS_FAST = 6'h04,
    LICS_CV = 6'h08,
    LICS_MAINT = 6'h10,
    LICS_HALT = 6'h20
  } lics_phase_t;

  // source of the fast charge current
  typedef enum logic [1:0] {
    LICS_CUR_OFF = 2'h0,
    LICS_CUR_RSET = 2'h1,
    LICS_CUR_USB = 2'h2
  } lics_cur_t;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic adapter_det;
    logic usb_det;
    logic vbat_low;
    logic vbat_cv;
    logic ichg_eoc;
    logic vbat_sag;
  } lics_sense_t;

  typedef struct packed {
    logic [1:0] trickle_v_sel;
    logic [1:0] trickle_i_sel;
    logic ext_power;
    logic ext_sense;
  } lics_otp_t;

  typedef struct packed {
    logic trickle_on;
    logic cc_on;
    logic cv_on;
    logic path_adapter;
    logic path_usb;
    lics_cur_t cur_src;
    logic [1:0] usb_current_field;
    logic [1:0] vsel;
    logic [1:0] trickle_v_sel;
    logic [1:0] trickle_i_sel;
    logic ext_drive;
    logic ext_sense;
  } lics_drive_t;

  typedef struct packed {
    logic [31:0] pre;
    logic [11:0] secs;
    logic expired;
  } lics_wd_t;

  typedef struct packed {
    lics_phase_t phase;
    logic [7:0] ctrl_a;
    logic en;
    logic wd_en;
    logic [1:0] wd_per;
    logic wd_refresh;
    logic wd_from_fast;
    logic [3:0] irq_st;
    logic [3:0] irq_mask;
    logic [7:0] rdata;
    logic pd_oe;
    logic eoc_oe;
    lics_drive_t drive;
  } lics_main_t;

endpackage : lics_pkg

// >>> lics_in_reg.sv
// input stage: registers the comparator and detection inputs
// assumes inputs are synchronous to clk
`timescale 1ns/1ps
module lics_in_reg
  import lics_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire lics_sense_t sense_in,
  output lics_sense_t sense_q
);

  lics_sense_t state_reg;
  lics_sense_t state_next;

  // next value is the present pin sample
  always_comb begin
    state_next = sense_in;
  end

  // sample register, cleared in reset so no source is seen
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next; // RULE_17
    end
  end

  assign sense_q = state_reg;

endmodule : lics_in_reg

// >>> lics_watchdog.sv
// charge watchdog: counts seconds while running, pulses expired at the selected period
// assumes a one-second tick count given as a parameter
`timescale 1ns/1ps
`include "lics_cfg.svh"
module lics_watchdog
  import lics_pkg::*;
#(
  parameter int unsigned SEC_CYCLES = `LICS_WD_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic clear,
  input wire logic [1:0] period,
  output logic expired
);

  generate
    if (SEC_CYCLES < 2) begin : g_bad_tick
      $error("lics_watchdog: SEC_CYCLES must be at least 2");
    end
  endgenerate

  // period code to seconds
  function automatic logic [11:0] limit_secs(input logic [1:0] code);
    int unsigned m;
    unique case (code)
      2'h0: m = `LICS_WD_MIN_0;
      2'h1: m = `LICS_WD_MIN_1;
      2'h2: m = `LICS_WD_MIN_2;
      2'h3: m = `LICS_WD_MIN_3;
    endcase
    return 12'(m * `LICS_SEC_PER_MIN);
  endfunction : limit_secs

  lics_wd_t state_reg;
  lics_wd_t state_next;

  // prescaler to seconds, then seconds to the period; holds when not running
  always_comb begin
    state_next = state_reg;
    state_next.expired = 1'b0;
    if (clear) begin
      state_next.pre = '0;
      state_next.secs = '0;
    end else if (run) begin
      if (state_reg.pre == 32'(SEC_CYCLES - 1)) begin
        state_next.pre = '0;
        if (state_reg.secs == limit_secs(period) - 12'h001) begin
          state_next.secs = '0;
          state_next.expired = 1'b1; // RULE_16
        end else begin
          state_next.secs = state_reg.secs + 12'h001;
        end
      end else begin
        state_next.pre = state_reg.pre + 32'h1;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign expired = state_reg.expired;

endmodule : lics_watchdog

// >>> lics_sequencer.sv
// li-ion charge cycle sequencer: register port, phase machine, watchdog, interrupt
// assumes synchronous inputs, one clock, synchronous active-high reset
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "lics_cfg.svh"
module lics_sequencer
  import lics_pkg::*;
#(
  parameter int unsigned WD_SEC_CYCLES = `LICS_WD_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // comparators and detectors
  input wire lics_sense_t sense,
  // factory option bits
  input wire lics_otp_t otp,
  // open-drain status pins
  output logic source_present_n_o,
  output logic source_present_n_oe,
  output logic end_of_charge_n_o,
  output logic end_of_charge_n_oe,
  // analog control and interrupt
  output lics_drive_t drive,
  output logic irq
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  generate
    if (WD_SEC_CYCLES < 2) begin : g_bad_tick
      $error("lics_sequencer: WD_SEC_CYCLES must be at least 2");
    end
  endgenerate

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // phases in which current is forced into the battery
  function automatic logic is_charging(input lics_phase_t p);
    return (p == LICS_TRICKLE) || (p == LICS_FAST) || (p == LICS_CV);
  endfunction : is_charging

  // register read multiplexer, unmapped indices read zero
  function automatic logic [7:0] read_word(input logic [2:0] a, input lics_main_t s, input lics_sense_t q);
    logic [7:0] w;
    w = 8'h00;
    unique case (a)
      `LICS_OFS_CTRL_A: w = s.ctrl_a;
      `LICS_OFS_CTRL_B: begin
        w[`LICS_B_EN_BIT] = s.en;
        w[`LICS_B_WDEN_BIT] = s.wd_en;
        w[`LICS_B_WPER_LSB +: 2] = s.wd_per;
      end
      `LICS_OFS_STATUS: w = {q.adapter_det, q.adapter_det | q.usb_det, s.phase};
      `LICS_OFS_IRQ_ST: w = {4'h0, s.irq_st};
      `LICS_OFS_IRQ_MASK: w = {4'h0, s.irq_mask};
      default: w = 8'h00;
    endcase
    return w;
  endfunction : read_word

  // ---------------------------------------------------------------
  // input stage and watchdog
  // ---------------------------------------------------------------
  lics_sense_t sense_q;
  lics_main_t state_reg;
  lics_main_t state_next;
  logic wd_run;
  logic wd_clear;
  logic wd_expired;
  logic src_present;
  logic charge_go;

  lics_in_reg u_in_reg (
    .clk(clk),
    .sys_rst(sys_rst),
    .sense_in(sense),
    .sense_q(sense_q)
  );

  // watchdog runs in fast charge and constant voltage, and in trickle only when fallen back from either
  assign wd_run = state_reg.wd_en &&
                  ((state_reg.phase == LICS_FAST) || (state_reg.phase == LICS_CV) ||
                   ((state_reg.phase == LICS_TRICKLE) && state_reg.wd_from_fast)); // RULE_16
  assign wd_clear = state_reg.wd_refresh || !src_present || (state_reg.phase == LICS_IDLE);

  lics_watchdog #(
    .SEC_CYCLES(WD_SEC_CYCLES)
  ) u_watchdog (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(wd_run),
    .clear(wd_clear),
    .period(state_reg.wd_per),
    .expired(wd_expired)
  );

  // source presence on either input and the overall go condition
  assign src_present = sense_q.adapter_det | sense_q.usb_det;
  assign charge_go = src_present & state_reg.en; // RULE_01

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [3:0] evt;
    logic adapter_path;
    lics_cur_t cur;
    logic topping;
    evt = 4'h0;
    adapter_path = 1'b0;
    cur = LICS_CUR_OFF;
    topping = 1'b0;
    state_next = state_reg;
    state_next.rdata = 8'h00;
    state_next.wd_refresh = 1'b0;

    // register writes; the refresh bit is a one-cycle strobe
    if (reg_wr) begin
      unique case (reg_addr)
        `LICS_OFS_CTRL_A: state_next.ctrl_a = reg_wdata;
        `LICS_OFS_CTRL_B: begin
          state_next.en = reg_wdata[`LICS_B_EN_BIT];
          state_next.wd_refresh = reg_wdata[`LICS_B_WREF_BIT]; // RULE_16
          state_next.wd_en = reg_wdata[`LICS_B_WDEN_BIT];
          state_next.wd_per = reg_wdata[`LICS_B_WPER_LSB +: 2];
        end
        `LICS_OFS_IRQ_ST: state_next.irq_st = state_reg.irq_st & ~reg_wdata[3:0];
        `LICS_OFS_IRQ_MASK: state_next.irq_mask = reg_wdata[3:0];
        default: ;
      endcase
    end

    // read data appear in the cycle after the read strobe
    if (reg_rd) begin
      state_next.rdata = read_word(reg_addr, state_reg, sense_q);
    end

    // charge phase machine
    unique case (state_reg.phase)
      LICS_IDLE: begin
        if (charge_go) begin
          evt[`LICS_IRQ_START] = 1'b1; // RULE_01
          state_next.wd_from_fast = 1'b0;
          if (sense_q.vbat_low) begin
            state_next.phase = LICS_TRICKLE; // RULE_04
          end else begin
            state_next.phase = LICS_FAST; // RULE_05
          end
        end
      end
      LICS_TRICKLE: begin
        if (!sense_q.vbat_low) begin
          state_next.phase = LICS_FAST; // RULE_10
        end
      end
      LICS_FAST: begin
        if (sense_q.vbat_low) begin
          state_next.phase = LICS_TRICKLE;
          state_next.wd_from_fast = 1'b1; // RULE_16
        end else if (sense_q.vbat_cv) begin
          state_next.phase = LICS_CV; // RULE_06
        end
      end
      LICS_CV: begin
        if (sense_q.vbat_low) begin
          state_next.phase = LICS_TRICKLE;
          state_next.wd_from_fast = 1'b1;
        end else if (sense_q.ichg_eoc) begin
          state_next.phase = LICS_MAINT; // RULE_07
          evt[`LICS_IRQ_EOC] = 1'b1;
        end
      end
      LICS_MAINT: ; // RULE_09
      LICS_HALT: ;
      default: state_next.phase = LICS_IDLE;
    endcase

    // watchdog expiry stops the charge until re-enabled or replugged
    if (wd_expired && is_charging(state_reg.phase)) begin
      state_next.phase = LICS_HALT; // RULE_16
      evt[`LICS_IRQ_WDOG] = 1'b1;
    end

    // enable clear or source removal stops any charge
    if (!charge_go) begin
      if (!src_present && (state_reg.phase != LICS_IDLE)) begin
        evt[`LICS_IRQ_LOST] = 1'b1;
      end
      state_next.phase = LICS_IDLE; // RULE_09
    end

    // sticky status: a new event wins over a simultaneous clear
    state_next.irq_st = state_next.irq_st | evt;

    // end-of-charge pin follows the next phase so it changes with it; detect pin follows source presence
    state_next.pd_oe = src_present; // RULE_01
    state_next.eoc_oe = is_charging(state_next.phase); // RULE_03 RULE_07

    // path: adapter wins when both are present
    adapter_path = sense_q.adapter_det; // RULE_02
    if (adapter_path && !state_reg.ctrl_a[`LICS_A_SEL_BIT]) begin
      cur = LICS_CUR_RSET; // RULE_13
    end else if (state_reg.ctrl_a[`LICS_A_USBI_LSB +: 2] == `LICS_USBI_OFF) begin
      cur = LICS_CUR_OFF; // RULE_15
    end else begin
      cur = LICS_CUR_USB; // RULE_12
    end

    // maintenance tops up at the charge voltage when the battery sags
    topping = (state_next.phase == LICS_MAINT) && sense_q.vbat_sag; // RULE_08

    // analog control word
    state_next.drive.trickle_on = (state_next.phase == LICS_TRICKLE); // RULE_10
    state_next.drive.cc_on = (state_next.phase == LICS_FAST) && (cur != LICS_CUR_OFF); // RULE_05
    state_next.drive.cv_on = (state_next.phase == LICS_CV) || topping; // RULE_06
    state_next.drive.path_adapter = (is_charging(state_next.phase) || topping) && adapter_path;
    state_next.drive.path_usb = (is_charging(state_next.phase) || topping) && !adapter_path &&
                                sense_q.usb_det; // RULE_12
    // a top-up draws from the same current source as the charge it continues
    state_next.drive.cur_src = (is_charging(state_next.phase) || topping) ? cur : LICS_CUR_OFF;
    state_next.drive.usb_current_field = state_reg.ctrl_a[`LICS_A_USBI_LSB +: 2]; // RULE_15
    state_next.drive.vsel = state_reg.ctrl_a[`LICS_A_VSEL_LSB +: 2]; // RULE_06
    state_next.drive.trickle_v_sel = otp.trickle_v_sel; // RULE_11
    state_next.drive.trickle_i_sel = otp.trickle_i_sel; // RULE_11
    state_next.drive.ext_drive = state_next.drive.path_adapter && otp.ext_power &&
                                 (cur == LICS_CUR_RSET); // RULE_14
    state_next.drive.ext_sense = otp.ext_sense; // RULE_14
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= '0;
      state_reg.phase <= LICS_IDLE; // RULE_17
      state_reg.ctrl_a <= `LICS_CTRL_A_RST;
      state_reg.en <= `LICS_EN_RST;
      state_reg.wd_en <= `LICS_WDEN_RST;
      state_reg.wd_per <= `LICS_WPER_RST;
      state_reg.irq_mask <= `LICS_IRQ_MASK_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // open-drain pins only ever pull low
  assign source_present_n_o = 1'b0;
  assign source_present_n_oe = state_reg.pd_oe;
  assign end_of_charge_n_o = 1'b0;
  assign end_of_charge_n_oe = state_reg.eoc_oe;
  assign drive = state_reg.drive;
  assign reg_rdata = state_reg.rdata;
  assign irq = |(state_reg.irq_st & state_reg.irq_mask); // level interrupt

endmodule : lics_sequencer

// >>> lics_sequencer_sva.sv
// checker of the charge sequencer: relations between its port signals over time
// assumes sense reaches the outputs two edges after the pins and all outputs are registered
`timescale 1ns/1ps
module lics_sequencer_chk
  import lics_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire lics_sense_t sense,
  input wire logic source_present_n_o,
  input wire logic source_present_n_oe,
  input wire logic end_of_charge_n_o,
  input wire logic end_of_charge_n_oe,
  input wire lics_drive_t drive
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ---------------------------------------------------------------
  // sequences
  // ---------------------------------------------------------------
  // no source seen on two sampled cycles in a row
  sequence s_no_src;
    !(sense.adapter_det || sense.usb_det) [*2];
  endsequence
  // two edges clear of reset, so both register stages hold real data
  sequence s_settled;
    !$past(sys_rst) && !$past(sys_rst, 2);
  endsequence

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  chk_pins_low: assert property (source_present_n_o == 1'b0 && end_of_charge_n_o == 1'b0)
    else $error("open drain data not low");
  chk_detect_pin: assert property (s_settled |-> source_present_n_oe == $past(sense.adapter_det || sense.usb_det, 2))
    else $error("detect pin does not follow sources");
  chk_gone_idle: assert property (s_no_src |=> !(drive.trickle_on || drive.cc_on || drive.cv_on) && !end_of_charge_n_oe)
    else $error("charge not stopped after source loss");
  chk_trickle_cause: assert property (drive.trickle_on |-> $past(sense.vbat_low, 2))
    else $error("trickle without low battery");
  chk_one_mode: assert property ($onehot0({drive.trickle_on, drive.cc_on, drive.cv_on}))
    else $error("more than one charge mode on");
  chk_path_prio: assert property (drive.path_usb |-> !drive.path_adapter && !$past(sense.adapter_det, 2))
    else $error("usb path while adapter present");
  chk_usb_field_off: assert property (drive.cur_src == LICS_CUR_USB |-> drive.usb_current_field != 2'h3)
    else $error("usb current with field off");
  chk_usb_only_usb: assert property (drive.path_usb |-> drive.cur_src != LICS_CUR_RSET)
    else $error("resistor current on usb input");
  chk_ext_drive_use: assert property (drive.ext_drive |-> drive.path_adapter && drive.cur_src == LICS_CUR_RSET)
    else $error("external device driven off adapter path");
  chk_eoc_start: assert property ($rose(end_of_charge_n_oe) |-> source_present_n_oe)
    else $error("end of charge low without source");
  chk_rd_stands: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule : lics_sequencer_chk

bind lics_sequencer lics_sequencer_chk u_lics_sequencer_chk (.clk(clk), .sys_rst(sys_rst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .sense(sense), .source_present_n_o(source_present_n_o),
  .source_present_n_oe(source_present_n_oe), .end_of_charge_n_o(end_of_charge_n_o),
  .end_of_charge_n_oe(end_of_charge_n_oe), .drive(drive));

// >>> lics_sequencer_bench.sv
// testbench of the charge sequencer: phase model, register model, directed and random runs
// assumes a short watchdog second of 4 cycles and a 125 mhz clock
`timescale 1ns/1ps
`include "lics_cfg.svh"
module lics_sequencer_bench
  import lics_pkg::*;
;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  lics_sense_t sense = '0;
  lics_otp_t otp = '0;
  logic pd_o, pd_oe, eoc_o, eoc_oe, irq;
  lics_drive_t drive;
  int error_cnt = 0, total_checks = 0, seed = 32'h9098, cyc = 0;
  int ph = 1, en = 0, wden = 1, per = 0, ist = 0, msk = 0, rdp = 0, rde = 0, src = 0, adp = 0;
  logic [7:0] ca = 8'h00;
  lics_sense_t s1 = '0;
  bit chk_on = 1;

  lics_sequencer #(.WD_SEC_CYCLES(4)) u_lics_sequencer (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sense(sense), .otp(otp),
    .source_present_n_o(pd_o), .source_present_n_oe(pd_oe), .end_of_charge_n_o(eoc_o),
    .end_of_charge_n_oe(eoc_oe), .drive(drive), .irq(irq));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // one register access, then a quiet cycle
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask : acc
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // clock and watchdog of the run
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      check("timeout", 1, 0);
      print_verdict();
    end
  end

  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  // phase, interrupt and register model on the registered sense copy
  always @(posedge clk) begin : model
    int nxt;
    if (sys_rst) begin
      ph = 1; en = 0; wden = 1; per = 0; ist = 0; msk = 0; ca = 8'h00; s1 = '0; rdp = 0; src = 0; adp = 0;
    end else begin
      rdp = reg_rd;
      src = s1.adapter_det || s1.usb_det;
      adp = s1.adapter_det;
      case (reg_addr)
        `LICS_OFS_CTRL_A: rde = ca;
        `LICS_OFS_CTRL_B: rde = per * 8 + wden * 4 + en;
        `LICS_OFS_STATUS: rde = ph + src * 64 + adp * 128;
        `LICS_OFS_IRQ_ST: rde = ist;
        `LICS_OFS_IRQ_MASK: rde = msk;
        default: rde = 0;
      endcase
      nxt = ph;
      case (ph)
        1: if (en && (s1.adapter_det || s1.usb_det)) nxt = s1.vbat_low ? 2 : 4;
        2: if (!s1.vbat_low) nxt = 4;
        4: nxt = s1.vbat_low ? 2 : (s1.vbat_cv ? 8 : 4);
        8: nxt = s1.vbat_low ? 2 : (s1.ichg_eoc ? 16 : 8);
        default: ;
      endcase
      if (!en || !src) nxt = 1;
      if (reg_wr && reg_addr == `LICS_OFS_IRQ_ST) ist &= ~reg_wdata;
      if (ph == 1 && nxt != 1) ist |= 1;
      if (ph == 8 && !s1.vbat_low && s1.ichg_eoc) ist |= 2;
      if (ph != 1 && !src) ist |= 8;
      ph = nxt;
      if (reg_wr && reg_addr == `LICS_OFS_CTRL_A) ca = reg_wdata;
      if (reg_wr && reg_addr == `LICS_OFS_CTRL_B) begin
        per = reg_wdata[4:3];
        wden = reg_wdata[2];
        en = reg_wdata[0];
      end
      if (reg_wr && reg_addr == `LICS_OFS_IRQ_MASK) msk = reg_wdata & 8'h0f;
      s1 = sense;
    end
  end

  // compare the design with the model every cycle while chk_on is set
  always @(negedge clk) begin
    if (!sys_rst && chk_on) begin
      check("eoc_oe", eoc_oe, ph == 2 || ph == 4 || ph == 8);
      check("pd_oe", pd_oe, src);
      check("trickle_on", drive.trickle_on, ph == 2);
      check("irq", irq, (ist & msk) != 0);
      if (ph != 16) check("cv_on", drive.cv_on, ph == 8);
      if (rdp) check("reg_rdata", reg_rdata, rde);
    end
  end

  // ---------------------------------------------------------------
  // stimulus
  // ---------------------------------------------------------------
  initial begin : main
    int i, f;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    otp <= 6'b100110;
    @(posedge clk);
    for (i = 0; i < 8; i++) acc(0, i[2:0], 8'h00);
    acc(1, `LICS_OFS_IRQ_MASK, 8'h0f);
    acc(1, `LICS_OFS_CTRL_B, 8'h01);
    // one full cycle: trickle, fast, cv, maintenance, top-up, unplug
    for (i = 0; i < 6; i++) begin
      case (i)
        0: sense <= 6'b111000;
        1: sense <= 6'b110000;
        2: sense <= 6'b110100;
        3: sense <= 6'b110010;
        4: sense <= 6'b110011;
        default: sense <= 6'b000000;
      endcase
      repeat (4) @(posedge clk);
      acc(0, `LICS_OFS_STATUS, 8'h00);
      acc(0, `LICS_OFS_IRQ_ST, 8'h00);
      @(negedge clk);
      if (i == 4) check("topup", {drive.cv_on, eoc_oe}, 2'b10);
      @(posedge clk);
      if (i == 3 || i == 5) acc(1, `LICS_OFS_IRQ_ST, 8'h0f);
    end
    // current source, path and voltage setting over all field values
    for (i = 0; i < 16; i++) begin
      sense <= {i[3], 5'b10000};
      acc(1, `LICS_OFS_CTRL_A, {i[1:0], i[2], i[3:2], 3'h0});
      repeat (3) @(posedge clk);
      @(negedge clk);
      f = (i[3] && !i[2]) ? 1 : (i[1:0] == 2'h3 ? 0 : 2);
      check("cur_src", drive.cur_src, f);
      check("path_adapter", drive.path_adapter, i[3]);
      check("cc_on", drive.cc_on, f != 0);
      check("usb_field", drive.usb_current_field, i[1:0]);
      check("vsel", drive.vsel, i[3:2]);
      check("ext_drive", drive.ext_drive, f == 1 && otp.ext_power);
      check("trickle_sel", {drive.trickle_v_sel, drive.trickle_i_sel}, otp[5:2]);
      @(posedge clk);
    end
    // random sources, battery levels and register traffic
    for (i = 0; i < 300; i++) begin
      f = $random(seed);
      sense <= f[21:16];
      case (f[2:0])
        0: acc(1, `LICS_OFS_CTRL_B, {7'h00, f[6] | f[7]});
        1: acc(1, `LICS_OFS_CTRL_A, f[15:8]);
        2: acc(1, `LICS_OFS_IRQ_ST, {4'h0, f[11:8]});
        3: acc(0, f[5] ? `LICS_OFS_IRQ_ST : 3'h5 + f[9:8], 8'h00);
        default: @(posedge clk);
      endcase
    end
    // watchdog: idle in trickle, then expiry counted from a refresh
    acc(1, `LICS_OFS_CTRL_B, 8'h00);
    sense <= 6'b011000;
    acc(1, `LICS_OFS_CTRL_B, 8'h05);
    repeat (300) @(posedge clk);
    @(negedge clk);
    check("trickle_hold", eoc_oe, 1);
    @(posedge clk);
    chk_on = 0;
    sense <= 6'b010000;
    repeat (150) @(posedge clk);
    acc(1, `LICS_OFS_CTRL_B, 8'h07);
    for (f = 0; f < 300 && eoc_oe !== 1'b0; f++) @(negedge clk);
    check("wd_expiry", f >= 230 && f <= 250, 1);
    check("halt_off", {drive.trickle_on, drive.cc_on, drive.cv_on}, 0);
    @(posedge clk);
    // second reset in mid-run, then reset values again
    sys_rst <= 1'b1;
    sense <= 6'b000000;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    chk_on = 1;
    @(posedge clk);
    for (i = 0; i < 8; i++) acc(0, i[2:0], 8'h00);
    print_verdict();
  end
endmodule : lics_sequencer_bench
